// >>> src/serial_dac_input_port.sv
`include "serial_dac_regs.svh"
// Operation
// - Active-low frame select enables the shift register only while low.
// - Data sampled on the first sixteen serial clock falling edges inside a frame.
// - Serial clock up to 30 MHz; host never exceeds it.
// - Shift register holds exactly sixteen bits.
// - Sixteenth falling edge with select low loads the word.
// - Select rising before sixteenth edge aborts; nothing changes.
// - Code is straight binary, output is supply times code over 16384.
// - Code decodes to exactly one closed tap switch.
// - Code zero selects the bottom tap, zero volts.
// - Top two bits choose normal or one of three power-down modes.
// - Reset clears the code; output stays zero until a full write.
// - Power-down leaves the stored code untouched.
module serial_dac_input_port
  import serial_dac_pkg::*;
#(
  parameter int CODE_BITS = `CODE_BITS
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic din,
  output logic [CODE_BITS-1:0] dac_code,
  output logic [1:0] op_mode,
  output logic [(1<<CODE_BITS)-1:0] tap_select,
  output logic amp_enable,
  output logic load_1k,
  output logic load_100k,
  output logic word_loaded
);
  ////////////////////////////////////////////////////////////
  // Pin synchronisers: the first stage feeds only the second
  localparam int PIN_COUNT = 3;
  localparam int PIN_SYNC = 2;
  localparam int PIN_SCLK = 1;
  localparam int PIN_DIN = 0;
  // Reset to the idle levels so that no false edge follows reset
  localparam logic [PIN_COUNT-1:0] PIN_IDLE = `PIN_IDLE_LEVELS;

  logic [PIN_COUNT-1:0] pin_raw;
  wire logic [PIN_COUNT-1:0] pin_sync;
  logic sync_n_s, sclk_s, din_s, sclk_prev;

  assign pin_raw = {sync_n, sclk, din};

  generate
    for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
      logic stage_one;
      logic stage_two;

      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          stage_one <= PIN_IDLE[p];
        end else begin
          stage_one <= pin_raw[p];
        end
      end

      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          stage_two <= PIN_IDLE[p];
        end else begin
          stage_two <= stage_one;
        end
      end

      assign pin_sync[p] = stage_two;
    end
  endgenerate

  assign sync_n_s = pin_sync[PIN_SYNC];
  assign sclk_s = pin_sync[PIN_SCLK];
  assign din_s = pin_sync[PIN_DIN];

  // Previous synchronised serial clock level, for edge detection
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sclk_prev <= PIN_IDLE[PIN_SCLK];
    end else begin
      sclk_prev <= sclk_s;
    end
  end

  // Oversampled link: each serial clock level must last at least two clocks
  logic sclk_fall;
  assign sclk_fall = sclk_prev & ~sclk_s;

  ////////////////////////////////////////////////////////////
  frame_state_t state;
  logic [`WORD_BITS-1:0] shift;
  logic [4:0] bit_count;
  logic frame_open;

  assign frame_open = ~sync_n_s;

  // A falling serial clock counts only while shifting inside an open frame
  function automatic logic bit_taken(input frame_state_t st, input logic is_open, input logic fall);
    return (st == st_shift) && is_open && fall;
  endfunction : bit_taken

  function automatic logic last_bit(input logic [4:0] count);
    return count == (`BIT_COUNT_LAST - 5'h1);
  endfunction : last_bit

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= st_idle;
    end else begin
      case (state)
        st_idle: begin
          if (frame_open) begin
            state <= st_shift;
          end
        end
        st_shift: begin
          if (!frame_open) begin
            state <= st_idle;
          end else if (bit_taken(state, frame_open, sclk_fall) && last_bit(bit_count)) begin
            state <= st_done;
          end
        end
        st_done: begin
          // Further edges ignored until select goes high again
          if (!frame_open) begin
            state <= st_idle;
          end
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bit_count <= 5'h0;
    end else if (state != st_shift || !frame_open) begin
      bit_count <= 5'h0;
    end else if (bit_taken(state, frame_open, sclk_fall)) begin
      bit_count <= bit_count + 5'h1;
    end
  end

  // Sampling needs the st_shift state, so a falling edge coincident
  // with the select fall is not taken; host setup time covers this.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      shift <= 16'h0000;
    end else if (bit_taken(state, frame_open, sclk_fall)) begin
      shift <= {shift[`WORD_BITS-2:0], din_s};
    end
  end

  ////////////////////////////////////////////////////////////
  word_load_if load_bus ();
  assign load_bus.load = bit_taken(state, frame_open, sclk_fall) && last_bit(bit_count);
  assign load_bus.word = {shift[`WORD_BITS-2:0], din_s};

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      word_loaded <= 1'b0;
    end else begin
      word_loaded <= load_bus.load;
    end
  end

  op_mode_t mode_q;
  assign op_mode = mode_q;

  dac_output_stage #(
    .CODE_BITS(CODE_BITS)
  ) u_stage (
    .clock(clock),
    .reset_n(reset_n),
    .load_port(load_bus),
    .dac_code(dac_code),
    .op_mode(mode_q),
    .tap_select(tap_select),
    .amp_enable(amp_enable),
    .load_1k(load_1k),
    .load_100k(load_100k)
  );
endmodule : serial_dac_input_port

// >>> src/serial_dac_regs.svh
`ifndef SERIAL_DAC_REGS_SVH
`define SERIAL_DAC_REGS_SVH
`define WORD_BITS 16
`define CODE_BITS 14
`define CODE_LSB 0
`define MODE_LSB 14
`define MODE_RESET 2'h0
`define CODE_RESET 14'h0000
`define FULL_SCALE 16384
`define BIT_COUNT_LAST 5'h10
`define SCLK_MAX_MHZ 30
`define SYNC_HIGH_MIN_NS 33
`define PIN_IDLE_LEVELS 3'h6
`endif

// >>> src/serial_dac_pkg.sv
package serial_dac_pkg;
  typedef enum logic [1:0] {
    mode_normal = 2'b00,
    mode_pd_1k = 2'b01,
    mode_pd_100k = 2'b10,
    mode_pd_tristate = 2'b11
  } op_mode_t;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_shift = 2'b01,
    st_done = 2'b10
  } frame_state_t;
endpackage : serial_dac_pkg

// >>> src/word_load_if.sv
interface word_load_if;
  logic load;
  logic [15:0] word;
  modport source (output load, output word);
  modport sink (input load, input word);
endinterface : word_load_if

// >>> src/dac_output_stage.sv
`include "serial_dac_regs.svh"
module dac_output_stage
  import serial_dac_pkg::*;
#(
  parameter int CODE_BITS = `CODE_BITS
) (
  input wire logic clock,
  input wire logic reset_n,
  word_load_if.sink load_port,
  output logic [CODE_BITS-1:0] dac_code,
  output op_mode_t op_mode,
  output logic [(1<<CODE_BITS)-1:0] tap_select,
  output logic amp_enable,
  output logic load_1k,
  output logic load_100k
);
  ////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dac_code <= `CODE_RESET;
    end else if (load_port.load) begin
      dac_code <= load_port.word[CODE_BITS-1:0];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      op_mode <= mode_normal;
    end else if (load_port.load) begin
      op_mode <= op_mode_t'(load_port.word[`MODE_LSB +: 2]);
    end
  end

  ////////////////////////////////////////////////////////////
  // One-hot tap: code 0 closes the bottom switch; Vout = Vdd*D/16384
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tap_select <= {{((1<<CODE_BITS)-1){1'b0}}, 1'b1};
    end else begin
      tap_select <= {{((1<<CODE_BITS)-1){1'b0}}, 1'b1} << dac_code;
    end
  end

  // Power-down only switches the output stage; the code is kept
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      amp_enable <= 1'b1;
      load_1k <= 1'b0;
      load_100k <= 1'b0;
    end else begin
      amp_enable <= (op_mode == mode_normal);
      load_1k <= (op_mode == mode_pd_1k);
      load_100k <= (op_mode == mode_pd_100k);
    end
  end
endmodule : dac_output_stage

// >>> test/serial_dac_input_port_properties.sv
module serial_dac_input_port_properties #(
  parameter int CODE_BITS = 14
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic sync_n,
  input wire logic [CODE_BITS-1:0] dac_code,
  input wire logic [1:0] op_mode,
  input wire logic [(1<<CODE_BITS)-1:0] tap_select,
  input wire logic amp_enable,
  input wire logic load_1k,
  input wire logic load_100k,
  input wire logic word_loaded
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_tap_one_hot: assert property ($onehot(tap_select)) else $error("tap");
  a_tap_at_code: assert property (tap_select[$past(dac_code)]) else $error("tap code");
  a_amp_normal: assert property (amp_enable == ($past(op_mode) == 2'h0)) else $error("amp");
  a_load_1k: assert property (load_1k == ($past(op_mode) == 2'h1)) else $error("1k");
  a_load_100k: assert property (load_100k == ($past(op_mode) == 2'h2)) else $error("100k");
  a_code_on_load: assert property (!$stable(dac_code) |-> word_loaded) else $error("code");
  a_mode_on_load: assert property (!$stable(op_mode) |-> word_loaded) else $error("mode");
  a_idle_no_load: assert property (sync_n [*8] |-> !word_loaded) else $error("idle");
endmodule : serial_dac_input_port_properties
bind serial_dac_input_port serial_dac_input_port_properties #(.CODE_BITS(CODE_BITS)) props_inst (.clock,
  .reset_n, .sync_n, .dac_code, .op_mode, .tap_select, .amp_enable, .load_1k, .load_100k, .word_loaded);

// >>> test/spi_host_model.sv
module spi_host_model (
  input wire logic clock,
  output logic sync_n,
  output logic sclk,
  output logic din
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sync_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end
  // Bits past the sixteenth are filler edges
  task automatic send(input logic [15:0] w, input int n, input int half);
    @(negedge clock) sync_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      din = (i < 16) ? w[15-i] : ~din;
      repeat (half) @(negedge clock);
      sclk = 1'b0;
      repeat (half) @(negedge clock);
      sclk = 1'b1;
    end
    sync_n = 1'b1;
    din = ~din;
    repeat (2 * half) @(negedge clock);
  endtask : send
endmodule : spi_host_model

// >>> test/serial_dac_input_port_tb.sv
module serial_dac_input_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, reset_n, sync_n, sclk, din, amp_enable, load_1k, load_100k, word_loaded;
  logic [13:0] dac_code;
  logic [1:0] op_mode;
  logic [16383:0] tap_select;
  logic [15:0] exp_q[$];
  logic [15:0] w;
  logic [15:0] exp_w;
  int num_errors = 0;
  int checked = 0;
  serial_dac_input_port serial_dac_input_port_inst (.clock, .reset_n, .sync_n, .sclk, .din, .dac_code,
    .op_mode, .tap_select, .amp_enable, .load_1k, .load_100k, .word_loaded);
  spi_host_model spi_host_model_inst (.clock, .sync_n, .sclk, .din);
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_stage(input logic [15:0] e);
    logic [15:0] got;
    logic [15:0] exp;
    got = {12'h000, $onehot(tap_select) && tap_select[e[13:0]], amp_enable, load_1k, load_100k};
    exp = {12'h000, 1'b1, e[15:14] == 2'h0, e[15:14] == 2'h1, e[15:14] == 2'h2};
    chk(got, exp);
  endtask : chk_stage
  task automatic summarize();
    $display("checked %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  always @(negedge clock) begin
    if (word_loaded === 1'b1) begin
      exp_w = exp_q.size() ? exp_q.pop_front() : 16'hXXXX;
      chk({op_mode, dac_code}, exp_w);
      @(negedge clock);
      chk_stage(exp_w);
    end
  end
  initial begin
    reset_n = 1'b0;
    w = 16'($urandom(71));
    repeat (4) @(negedge clock);
    reset_n = 1'b1;
    repeat (3) @(negedge clock);
    chk({op_mode, dac_code}, 16'h0000);
    chk({14'h0000, amp_enable, tap_select[0]}, 16'h0003);
    $display("reset test done");
    for (int m = 0; m < 6; m++) begin
      w = (m < 4) ? {m[1:0], 14'($urandom)} : {2'h0, {14{m[0]}}};
      exp_q.push_back(w);
      spi_host_model_inst.send(w, 16, 4);
    end
    $display("mode test done");
    spi_host_model_inst.send(~w, 15, 4);
    repeat (10) @(negedge clock);
    chk({op_mode, dac_code}, w);
    w = 16'($urandom);
    exp_q.push_back(w);
    spi_host_model_inst.send(w, 18, 4);
    repeat (10) @(negedge clock);
    chk(16'(exp_q.size()), 16'h0000);
    $display("abort test done");
    reset_n = 1'b0;
    repeat (4) @(negedge clock);
    reset_n = 1'b1;
    repeat (3) @(negedge clock);
    chk({op_mode, dac_code}, 16'h0000);
    chk({14'h0000, amp_enable, tap_select[0]}, 16'h0003);
    $display("mid-run reset test done");
    summarize();
  end
  initial begin
    #500000;
    num_errors++;
    summarize();
  end
endmodule : serial_dac_input_port_tb
